//--- eps_consts.svh
// constants for the encoder preset, offset and status block
`ifndef EPS_CONSTS_SVH
`define EPS_CONSTS_SVH

`define EPS_IDX_PRESET 16'h6003
`define EPS_IDX_POSITION 16'h6004
`define EPS_IDX_STATUS 16'h6500
`define EPS_IDX_PHYS_STEPS 16'h6501
`define EPS_IDX_PHYS_TURNS 16'h6502
`define EPS_IDX_ERRORS 16'h6503
`define EPS_IDX_ERR_CAP 16'h6504
`define EPS_IDX_WARNINGS 16'h6505
`define EPS_IDX_WARN_CAP 16'h6506
`define EPS_IDX_OFFSET 16'h6509
`define EPS_IDX_STORE 16'h1010
`define EPS_IDX_RESTORE 16'h1011

`define EPS_SUB_MAIN 8'h00
`define EPS_SUB_CMD 8'h01

`define EPS_CMD_WRITE4 8'h23
`define EPS_CMD_WRITE_ACK 8'h60
`define EPS_CMD_READ 8'h40
`define EPS_CMD_READ4_RESP 8'h43
`define EPS_CMD_READ2_RESP 8'h4b
`define EPS_CMD_ABORT 8'h80

`define EPS_ABORT_BAD_CMD 32'h0504_0001
`define EPS_ABORT_READ_ONLY 32'h0601_0002
`define EPS_ABORT_NO_OBJECT 32'h0602_0000
`define EPS_ABORT_NO_SUB 32'h0609_0011

`define EPS_PHYS_STEPS 32'h0001_0000
`define EPS_PHYS_TURNS 32'h0000_4000

`define EPS_ERR_CAP 16'h0000
`define EPS_WARN_CAP 16'h1000
`define EPS_WARN_FLASH_BIT 12
`define EPS_STAT_DIR_BIT 0
`define EPS_STAT_SCALE_BIT 2

`define EPS_PRESET_RST 32'h0000_0000
`define EPS_OFFSET_RST 32'h0000_0000
`define EPS_WARN_RST 16'h0000

`endif

//--- eps_pkg.sv
// types shared by the encoder preset, offset and status block
`default_nettype none

package eps_pkg;

    typedef enum logic [1:0] {
        EPS_ACC_READ = 2'b00,
        EPS_ACC_WRITE = 2'b01,
        EPS_ACC_BAD = 2'b10
    } eps_access_t;

    typedef struct packed {
        logic [31:0] data;
        logic [7:0] sub;
        logic [15:0] index;
        logic [7:0] cmd;
    } eps_sdo_t;

endpackage

`default_nettype wire

//--- eps_frame_if.sv
// decoded mailbox request travelling from the decoder to the object dictionary
`timescale 1ns/1ps
`default_nettype none

interface eps_frame_if;
    logic valid;
    eps_pkg::eps_sdo_t fields;
    eps_pkg::eps_access_t access;

    modport producer (output valid, output fields, output access);
    modport consumer (input valid, input fields, input access);
endinterface

`default_nettype wire

//--- eps_sdo_decode.sv
// splits an eight-byte mailbox request into command, index, subindex and data
`timescale 1ns/1ps
`default_nettype none
`include "eps_consts.svh"

module eps_sdo_decode (
    input wire logic frame_valid,
    input wire logic [63:0] frame,
    eps_frame_if.producer dec
);
    wire logic [7:0] cmd_byte = frame[7:0];

    // byte 0 command, bytes 1-2 index little-endian, byte 3 subindex, bytes 4-7 data
    assign dec.valid = frame_valid;
    assign dec.fields = frame;
    assign dec.access = (cmd_byte == `EPS_CMD_READ) ? eps_pkg::EPS_ACC_READ :
                        (cmd_byte == `EPS_CMD_WRITE4) ? eps_pkg::EPS_ACC_WRITE :
                        eps_pkg::EPS_ACC_BAD;
endmodule

`default_nettype wire

//--- eps_wrap_add.sv
// position plus preset minus offset, folded into zero to resolution minus one
`timescale 1ns/1ps
`default_nettype none

module eps_wrap_add (
    input wire logic [31:0] position,
    input wire logic [31:0] preset,
    input wire logic [31:0] offset,
    input wire logic [31:0] resolution,
    output logic [31:0] result
);
    wire logic [33:0] raw_sum = {2'b00, position} + {2'b00, preset} - {2'b00, offset};
    wire logic below_zero = raw_sum[33];
    wire logic at_or_above = !below_zero && (raw_sum >= {2'b00, resolution});
    wire logic [33:0] up_sum = raw_sum + {2'b00, resolution};
    wire logic [33:0] down_sum = raw_sum - {2'b00, resolution};

    // operands are each below the resolution, so one fold is enough
    assign result = below_zero ? up_sum[31:0] :
                    at_or_above ? down_sum[31:0] : raw_sum[31:0];
endmodule

`default_nettype wire

//--- eps_encoder_top.sv
// encoder position output stage with preset, captured offset and status objects
//
// Behaviour
// - position out is the read position plus the preset minus the captured offset.
// - with preset and offset at zero the position out equals the read position.
// - executing a preset copies the current encoder position into the captured offset.
// - a four-byte expedited write (23) to the preset is confirmed by 60 echoing index and sub.
// - a read-only 32-bit current position object is served and driven as cyclic data.
// - status bit 0 mirrors the counting direction, 0 rotation_right and 1 rotation_left.
// - status bit 2 mirrors the scaling enable, bits 1 and 3 to 15 read zero.
// - physical steps and turns set the resolution only while scaling is disabled.
// - total hardware resolution is physical steps per turn times physical turns.
// - error bits exist only where supported, and the error capability reads zero.
// - warning capability reads 1000h and bit 12 flags bad parameters loaded from flash.
// - the captured offset is read-only and returns to zero on reset, on factory restore or on a flash load flagged bad.
// - preset and offset reach nonvolatile storage only when the store command runs.
// - the preset applies to the position present in the cycle the value is received.
`timescale 1ns/1ps
`default_nettype none
`include "eps_consts.svh"

module eps_encoder_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [31:0] raw_position,
    input wire logic count_ccw_cfg,
    input wire logic scaling_enable_cfg,
    input wire logic [31:0] scaled_total_range,
    input wire logic mbx_req_valid,
    input wire logic [63:0] mbx_req_data,
    input wire logic flash_load_valid,
    input wire logic flash_params_bad,
    input wire logic [31:0] flash_preset,
    input wire logic [31:0] flash_offset,
    output logic [31:0] position_out,
    output logic mbx_resp_valid,
    output logic [63:0] mbx_resp_data,
    output logic nv_store_pulse,
    output logic [31:0] nv_preset,
    output logic [31:0] nv_offset,
    output logic flash_warning
);
    logic [31:0] preset_value;
    logic [31:0] captured_zero_reference;
    logic [15:0] active_warnings;

    eps_frame_if req_if ();

    eps_sdo_decode u_decode (
        .frame_valid(mbx_req_valid),
        .frame(mbx_req_data),
        .dec(req_if)
    );

    // resolution in force
    wire logic [63:0] hw_product = {32'h0000_0000, `EPS_PHYS_STEPS}
                                   * {32'h0000_0000, `EPS_PHYS_TURNS};
    wire logic [31:0] hw_total = hw_product[31:0];
    wire logic [31:0] active_res = scaling_enable_cfg ? scaled_total_range : hw_total;

    wire logic [31:0] next_position;

    eps_wrap_add u_wrap (
        .position(raw_position),
        .preset(preset_value),
        .offset(captured_zero_reference),
        .resolution(active_res),
        .result(next_position)
    );

    // read-only objects
    wire logic [15:0] operating_status = {13'h0000, scaling_enable_cfg, 1'b0, count_ccw_cfg};
    wire logic [15:0] error_capability = `EPS_ERR_CAP;
    wire logic [15:0] active_errors = 16'h0000 & error_capability;
    wire logic [15:0] warning_capability = `EPS_WARN_CAP;

    // request fields
    wire logic [15:0] idx = req_if.fields.index;
    wire logic [7:0] sub = req_if.fields.sub;
    wire logic [31:0] wdata = req_if.fields.data;
    wire logic is_read = req_if.access == eps_pkg::EPS_ACC_READ;
    wire logic is_write = req_if.access == eps_pkg::EPS_ACC_WRITE;
    wire logic bad_cmd = req_if.access == eps_pkg::EPS_ACC_BAD;

    wire logic is_preset = idx == `EPS_IDX_PRESET;
    wire logic is_pos = idx == `EPS_IDX_POSITION;
    wire logic is_stat = idx == `EPS_IDX_STATUS;
    wire logic is_steps = idx == `EPS_IDX_PHYS_STEPS;
    wire logic is_turns = idx == `EPS_IDX_PHYS_TURNS;
    wire logic is_err = idx == `EPS_IDX_ERRORS;
    wire logic is_errcap = idx == `EPS_IDX_ERR_CAP;
    wire logic is_warn = idx == `EPS_IDX_WARNINGS;
    wire logic is_warncap = idx == `EPS_IDX_WARN_CAP;
    wire logic is_offset = idx == `EPS_IDX_OFFSET;
    wire logic is_store = idx == `EPS_IDX_STORE;
    wire logic is_restore = idx == `EPS_IDX_RESTORE;

    wire logic is_cmd_obj = is_store || is_restore;
    wire logic known = is_preset || is_pos || is_stat || is_steps || is_turns || is_err
                       || is_errcap || is_warn || is_warncap || is_offset || is_cmd_obj;
    wire logic sub_ok = is_cmd_obj ? (sub == `EPS_SUB_CMD) : (sub == `EPS_SUB_MAIN);
    wire logic writable = is_preset || is_cmd_obj;
    wire logic short_obj = is_stat || is_err || is_errcap || is_warn || is_warncap;
    wire logic req_ok = !bad_cmd && known && sub_ok && (is_read || writable);

    // object read selection
    wire logic [31:0] read_word =
        is_preset ? preset_value :
        is_pos ? position_out :
        is_stat ? {16'h0000, operating_status} :
        is_steps ? `EPS_PHYS_STEPS :
        is_turns ? `EPS_PHYS_TURNS :
        is_err ? {16'h0000, active_errors} :
        is_errcap ? {16'h0000, error_capability} :
        is_warn ? {16'h0000, active_warnings} :
        is_warncap ? {16'h0000, warning_capability} :
        is_offset ? captured_zero_reference : 32'h0000_0000;

    wire logic [31:0] abort_code =
        bad_cmd ? `EPS_ABORT_BAD_CMD :
        !known ? `EPS_ABORT_NO_OBJECT :
        !sub_ok ? `EPS_ABORT_NO_SUB : `EPS_ABORT_READ_ONLY;

    wire logic [7:0] resp_cmd =
        !req_ok ? `EPS_CMD_ABORT :
        is_write ? `EPS_CMD_WRITE_ACK :
        short_obj ? `EPS_CMD_READ2_RESP : `EPS_CMD_READ4_RESP;

    wire logic [31:0] resp_word = !req_ok ? abort_code : is_write ? 32'h0000_0000 : read_word;
    wire logic [63:0] next_resp = {resp_word, sub, idx, resp_cmd};

    // write effects
    wire logic wr_ok = req_if.valid && is_write && req_ok;
    wire logic preset_exec = wr_ok && is_preset;
    wire logic store_exec = wr_ok && is_store;
    wire logic restore_exec = wr_ok && is_restore;

    // power-on load, preset execution and factory restore
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            preset_value <= `EPS_PRESET_RST;
            captured_zero_reference <= `EPS_OFFSET_RST;
        end
        else if (flash_load_valid)
        begin
            preset_value <= flash_params_bad ? `EPS_PRESET_RST : flash_preset;
            captured_zero_reference <= flash_params_bad ? `EPS_OFFSET_RST : flash_offset;
        end
        else if (preset_exec)
        begin
            preset_value <= wdata;
            captured_zero_reference <= raw_position;
        end
        else if (restore_exec)
        begin
            preset_value <= `EPS_PRESET_RST;
            captured_zero_reference <= `EPS_OFFSET_RST;
        end
    end

    // warning flag from the flash load
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active_warnings <= `EPS_WARN_RST;
            flash_warning <= 1'b0;
        end
        else if (flash_load_valid)
        begin
            active_warnings <= {3'b000, flash_params_bad, 12'h000} & `EPS_WARN_CAP;
            flash_warning <= flash_params_bad;
        end
    end

    // cyclic position and mailbox answer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            position_out <= 32'h0000_0000;
            mbx_resp_valid <= 1'b0;
            mbx_resp_data <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            position_out <= next_position;
            mbx_resp_valid <= req_if.valid;
            if (req_if.valid)
                mbx_resp_data <= next_resp;
        end
    end

    // snapshot to nonvolatile storage on the store command
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nv_store_pulse <= 1'b0;
            nv_preset <= `EPS_PRESET_RST;
            nv_offset <= `EPS_OFFSET_RST;
        end
        else
        begin
            nv_store_pulse <= store_exec;
            if (store_exec)
            begin
                nv_preset <= preset_value;
                nv_offset <= captured_zero_reference;
            end
        end
    end

    // checks
    logic [31:0] chk_raw;
    logic [31:0] chk_pre;
    logic [31:0] chk_off;
    logic [31:0] chk_res;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chk_raw <= 32'h0000_0000;
            chk_pre <= 32'h0000_0000;
            chk_off <= 32'h0000_0000;
            chk_res <= 32'h0000_0000;
        end
        else
        begin
            chk_raw <= raw_position;
            chk_pre <= preset_value;
            chk_off <= captured_zero_reference;
            chk_res <= active_res;
        end
    end

    wire logic [35:0] chk_diff = {4'h0, position_out} + {4'h0, chk_off} - {4'h0, chk_pre}
                                 - {4'h0, chk_raw};
    wire logic [35:0] chk_res_w = {4'h0, chk_res};
    wire logic [35:0] chk_neg_res = 36'h0_0000_0000 - chk_res_w;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_preset_write;
        preset_exec;
    endsequence

    sequence s_preset_ack;
        mbx_resp_valid && mbx_resp_data[7:0] == 8'h60 && mbx_resp_data[23:8] == 16'h6003
        && mbx_resp_data[31:24] == 8'h00 && mbx_resp_data[63:32] == 32'h0000_0000;
    endsequence

    AST_SUM: assert property ($past(rst_n) |->
        (chk_diff == 36'h0_0000_0000 || chk_diff == chk_res_w || chk_diff == chk_neg_res))
        else $error("position out is not read position plus preset minus offset");

    AST_ZERO: assert property ((preset_value == 32'h0 && captured_zero_reference == 32'h0
        && raw_position < active_res && !flash_load_valid && !preset_exec)
        |=> position_out == $past(raw_position))
        else $error("zero preset and offset do not pass position through");

    AST_CAPTURE: assert property (s_preset_write |=>
        captured_zero_reference == $past(raw_position) && preset_value == $past(wdata))
        else $error("preset did not capture the current position");

    AST_ACK: assert property (s_preset_write |=> s_preset_ack)
        else $error("preset write was not confirmed with an echo");

    AST_ANSWER: assert property (mbx_req_valid |=> mbx_resp_valid)
        else $error("mailbox request was not answered in the next cycle");

    AST_WRAP: assert property ($past(rst_n) && chk_res != 32'h0 |-> position_out < chk_res)
        else $error("position out left the resolution range");

    AST_STATUS: assert property (mbx_req_valid && mbx_req_data[31:0] == 32'h0065_0040
        |=> mbx_resp_data[7:0] == 8'h4b && mbx_resp_data[47:32] == {13'h0000,
        $past(scaling_enable_cfg), 1'b0, $past(count_ccw_cfg)})
        else $error("status read does not mirror direction and scaling");

    AST_CAPS: assert property (active_errors == 16'h0000 && error_capability == 16'h0000
        && (active_warnings & 16'hefff) == 16'h0000)
        else $error("unsupported error or warning bit is set");

    AST_WARN: assert property (flash_load_valid |=>
        active_warnings[12] == $past(flash_params_bad) && flash_warning == $past(flash_params_bad))
        else $error("flash warning does not follow the load result");

    AST_OFFSET_RO: assert property (!flash_load_valid && !preset_exec && !restore_exec
        |=> $stable(captured_zero_reference))
        else $error("captured offset changed without preset, restore or load");

    AST_STORE: assert property (store_exec |=> nv_store_pulse && nv_offset ==
        $past(captured_zero_reference) ##1 !nv_store_pulse || $past(store_exec))
        else $error("store command did not snapshot once");

endmodule

`default_nettype wire

//--- eps_master_model.sv
// fieldbus master model issuing mailbox requests and collecting answers
`timescale 1ns/1ps
`default_nettype none

module eps_master_model (
    input wire logic sys_clk,
    output logic mbx_req_valid,
    output logic [63:0] mbx_req_data,
    input wire logic mbx_resp_valid,
    input wire logic [63:0] mbx_resp_data
);
    initial
    begin
        mbx_req_valid = 1'b0;
        mbx_req_data = 64'h0;
    end

    // one expedited request held for one edge, then the answer is collected
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] data, output logic [63:0] resp);
        int n;
        n = 0;
        @(negedge sys_clk);
        mbx_req_data = {data, sub, idx, cmd};
        mbx_req_valid = 1'b1;
        @(negedge sys_clk);
        mbx_req_valid = 1'b0;
        // released lines show the inverse, not the last value
        mbx_req_data = ~mbx_req_data;
        while (mbx_resp_valid !== 1'b1 && n < 4)
        begin
            @(negedge sys_clk);
            n++;
        end
        resp = (n < 4) ? mbx_resp_data : 64'hx;
    endtask
endmodule

`default_nettype wire

//--- tb_encoder_preset_offset_status.sv
// testbench for the encoder preset, offset and status block
`timescale 1ns/1ps
`default_nettype none
`include "eps_consts.svh"

module tb_encoder_preset_offset_status;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] raw_position = 32'h0;
    logic count_ccw_cfg = 1'b0;
    logic scaling_enable_cfg = 1'b0;
    logic [31:0] scaled_total_range = 32'h0000_0800;
    logic mbx_req_valid;
    logic [63:0] mbx_req_data;
    logic flash_load_valid = 1'b0;
    logic flash_params_bad = 1'b0;
    logic [31:0] flash_preset = 32'h0;
    logic [31:0] flash_offset = 32'h0;
    logic [31:0] position_out;
    logic mbx_resp_valid;
    logic [63:0] mbx_resp_data;
    logic nv_store_pulse;
    logic [31:0] nv_preset;
    logic [31:0] nv_offset;
    logic flash_warning;
    int fail_count = 0;
    int n_checks = 0;
    localparam logic [31:0] PHYS_RES = `EPS_PHYS_STEPS * `EPS_PHYS_TURNS;

    always #10 sys_clk = ~sys_clk;

    eps_encoder_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .raw_position(raw_position),
        .count_ccw_cfg(count_ccw_cfg), .scaling_enable_cfg(scaling_enable_cfg),
        .scaled_total_range(scaled_total_range), .mbx_req_valid(mbx_req_valid),
        .mbx_req_data(mbx_req_data), .flash_load_valid(flash_load_valid),
        .flash_params_bad(flash_params_bad), .flash_preset(flash_preset),
        .flash_offset(flash_offset), .position_out(position_out),
        .mbx_resp_valid(mbx_resp_valid), .mbx_resp_data(mbx_resp_data),
        .nv_store_pulse(nv_store_pulse), .nv_preset(nv_preset), .nv_offset(nv_offset),
        .flash_warning(flash_warning));

    eps_master_model u_master (.sys_clk(sys_clk), .mbx_req_valid(mbx_req_valid),
        .mbx_req_data(mbx_req_data), .mbx_resp_valid(mbx_resp_valid),
        .mbx_resp_data(mbx_resp_data));

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] rc, input logic [31:0] exp);
        logic [63:0] r;
        u_master.xfer(`EPS_CMD_READ, idx, `EPS_SUB_MAIN, 32'h0, r);
        check(r, {exp, `EPS_SUB_MAIN, idx, rc});
    endtask

    task automatic wr_ok(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
        logic [63:0] r;
        u_master.xfer(`EPS_CMD_WRITE4, idx, sub, d, r);
        check(r, {32'h0, sub, idx, 8'h60});
    endtask

    task automatic wr_abort(input logic [7:0] cmd, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] code);
        logic [63:0] r;
        u_master.xfer(cmd, idx, sub, 32'h0000_0001, r);
        check({24'h0, r[63:32], r[7:0]}, {24'h0, code, 8'h80});
    endtask

    // raw applied off the edge, output compared one edge later
    task automatic pos(input logic [31:0] raw, input logic [31:0] exp);
        raw_position = raw;
        @(negedge sys_clk);
        check(position_out, exp);
    endtask

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        summarize();
    end

    initial
    begin
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        pos(32'd1234, 32'd1234);
        rd(`EPS_IDX_ERR_CAP, 8'h4b, 32'h0000);
        rd(`EPS_IDX_ERRORS, 8'h4b, 32'h0000);
        rd(`EPS_IDX_WARN_CAP, 8'h4b, 32'h1000);
        rd(`EPS_IDX_WARNINGS, 8'h4b, 32'h0000);
        rd(`EPS_IDX_PHYS_STEPS, 8'h43, `EPS_PHYS_STEPS);
        rd(`EPS_IDX_PHYS_TURNS, 8'h43, `EPS_PHYS_TURNS);
        rd(`EPS_IDX_POSITION, 8'h43, 32'd1234);
        rd(`EPS_IDX_OFFSET, 8'h43, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            count_ccw_cfg = i[0];
            scaling_enable_cfg = i[1];
            rd(`EPS_IDX_STATUS, 8'h4b, {29'h0, i[1], 1'b0, i[0]});
        end
        count_ccw_cfg = 1'b0;
        scaling_enable_cfg = 1'b0;
        raw_position = 32'd1000;
        wr_ok(`EPS_IDX_PRESET, `EPS_SUB_MAIN, 32'd50);
        pos(32'd1001, 32'd51);
        pos(32'd999, 32'd49);
        rd(`EPS_IDX_OFFSET, 8'h43, 32'd1000);
        rd(`EPS_IDX_PRESET, 8'h43, 32'd50);
        pos(32'd900, PHYS_RES - 32'd50);
        scaling_enable_cfg = 1'b1;
        pos(32'd10, 32'd1108);
        wr_ok(`EPS_IDX_PRESET, `EPS_SUB_MAIN, 32'd50);
        pos(32'd2047, 32'd39);
        scaling_enable_cfg = 1'b0;
        raw_position = 32'd1000;
        wr_ok(`EPS_IDX_PRESET, `EPS_SUB_MAIN, 32'd50);
        wr_abort(`EPS_CMD_WRITE4, `EPS_IDX_OFFSET, 8'h00, `EPS_ABORT_READ_ONLY);
        wr_abort(8'h21, `EPS_IDX_PRESET, 8'h00, `EPS_ABORT_BAD_CMD);
        wr_abort(`EPS_CMD_WRITE4, 16'h6000, 8'h00, `EPS_ABORT_NO_OBJECT);
        wr_abort(`EPS_CMD_WRITE4, `EPS_IDX_PRESET, 8'h01, `EPS_ABORT_NO_SUB);
        rd(`EPS_IDX_OFFSET, 8'h43, 32'd1000);
        wr_ok(`EPS_IDX_STORE, `EPS_SUB_CMD, 32'h6576_6173);
        check(nv_store_pulse, 1'b1);
        check({nv_preset, nv_offset}, {32'd50, 32'd1000});
        @(negedge sys_clk);
        check(nv_store_pulse, 1'b0);
        wr_ok(`EPS_IDX_RESTORE, `EPS_SUB_CMD, 32'h0);
        pos(32'd1234, 32'd1234);
        rd(`EPS_IDX_OFFSET, 8'h43, 32'h0);
        check({nv_preset, nv_offset}, {32'd50, 32'd1000});
        flash_preset = 32'd7;
        flash_offset = 32'd2;
        flash_params_bad = 1'b1;
        flash_load_valid = 1'b1;
        @(negedge sys_clk);
        flash_load_valid = 1'b0;
        flash_params_bad = 1'b0;
        check(flash_warning, 1'b1);
        rd(`EPS_IDX_WARNINGS, 8'h4b, 32'h1000);
        pos(32'd100, 32'd100);
        flash_load_valid = 1'b1;
        @(negedge sys_clk);
        flash_load_valid = 1'b0;
        check(flash_warning, 1'b0);
        pos(32'd100, 32'd105);
        summarize();
    end
endmodule

`default_nettype wire
